// ### shared/wft_pkg.sv
package wft_pkg;

    // ------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------
    localparam int NUM_EP = 4;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int BUS_W = 16;
    localparam int TC_W = 32;

    // ------------------------------------------------------------
    // register offsets, per endpoint in order ep2, ep4, ep6, ep8
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_FLAG_SELECT [NUM_EP] =
        '{16'he6d2, 16'he6da, 16'he6e2, 16'he6ea};
    localparam logic [15:0] OFS_FLAG_STOP [NUM_EP] =
        '{16'he6d3, 16'he6db, 16'he6e3, 16'he6eb};
    localparam logic [15:0] OFS_FIFO_TRIGGER [NUM_EP] =
        '{16'he6d4, 16'he6dc, 16'he6e4, 16'he6ec};
    // transaction count bytes, byte 3 first
    localparam logic [15:0] OFS_TC_BYTE [4] =
        '{16'he6ce, 16'he6cf, 16'he6d0, 16'he6d1};
    localparam logic [15:0] OFS_SINGLE_HIGH = 16'he6f0;
    localparam logic [15:0] OFS_SINGLE_LOW = 16'he6f1;
    localparam logic [15:0] OFS_SINGLE_LOW_QUIET = 16'he6f2;
    localparam logic [15:0] OFS_BUS_CONFIG = 16'he6f6;
    localparam logic [15:0] OFS_ENGINE_STATUS = 16'he6f7;

    // ------------------------------------------------------------
    // field positions and values
    // ------------------------------------------------------------
    localparam int FLAG_CHOICE_LSB = 0;
    localparam int STOP_BIT_POS = 0;
    localparam int WIDE_BIT_POS = 0;
    localparam logic [7:0] TRIGGER_WRITE_VALUE = 8'hff;
    localparam logic [1:0] FLAG_CHOICE_PROG = 2'h0;
    localparam logic [1:0] FLAG_CHOICE_EMPTY = 2'h1;
    localparam logic [1:0] FLAG_CHOICE_FULL = 2'h2;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [1:0] FLAG_CHOICE_RESET = 2'h0;
    localparam logic STOP_RESET = 1'b0;
    localparam logic WIDE_RESET = 1'b0;
    localparam logic [31:0] TC_RESET = 32'h0000_0001;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic prog;
        logic empty;
        logic full;
    } wft_flags_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b10
    } wft_state_type;

    typedef enum logic [1:0] {
        K_SINGLE_WR = 2'b00,
        K_SINGLE_RD = 2'b01,
        K_FIFO_WR = 2'b10,
        K_FIFO_RD = 2'b11
    } wft_kind_type;

endpackage : wft_pkg

// ### core/wft_sync.sv
`timescale 1ns/1ps
module wft_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [wft_pkg::BUS_W-1:0] async_in,
    output logic [wft_pkg::BUS_W-1:0] sync_out
);
    import wft_pkg::*;

    logic [BUS_W-1:0] meta_r;
    logic [BUS_W-1:0] meta_nxt;
    logic [BUS_W-1:0] sync_nxt;

    // ------------------------------------------------------------
    // two flip-flop synchroniser for the bus pins
    // ------------------------------------------------------------
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r; // first stage feeds only the second
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else if (ce)
        begin
            meta_r <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end

endmodule : wft_sync

// ### core/wft_flag_mux.sv
`timescale 1ns/1ps
module wft_flag_mux (
    input wft_pkg::wft_flags_type [wft_pkg::NUM_EP-1:0] fifo_flags,
    input wire logic [wft_pkg::NUM_EP*2-1:0] flag_choice_field,
    output logic [wft_pkg::NUM_EP-1:0] engine_flag
);
    import wft_pkg::*;

    // ------------------------------------------------------------
    // one flag per endpoint reaches the engine
    // ------------------------------------------------------------
    for (genvar e = 0; e < NUM_EP; e++)
    begin : g_ep
        // selected flag replaces the others; reserved code gives zero
        always_comb
        begin
            case (flag_choice_field[e*2 +: 2])
                FLAG_CHOICE_PROG: engine_flag[e] = fifo_flags[e].prog;
                FLAG_CHOICE_EMPTY: engine_flag[e] = fifo_flags[e].empty;
                FLAG_CHOICE_FULL: engine_flag[e] = fifo_flags[e].full;
                default: engine_flag[e] = 1'b0;
            endcase
        end
    end

endmodule : wft_flag_mux

// ### core/wft_ctrl.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
// How it works
// - flag choice field routes one flag
// - engine sees only one flag per endpoint
// - stop bit set: selected flag ends transaction
// - writing ff to trigger starts fifo write
// - reading trigger register starts fifo read
// - high data register holds bus bits 15:8
// - low data access starts one transaction
// - transaction count reads show live progress
// - quiet low register transfers, never triggers
module wft_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [wft_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wft_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [wft_pkg::DATA_W-1:0] reg_rdata,
    input wft_pkg::wft_flags_type [wft_pkg::NUM_EP-1:0] fifo_flags,
    output logic [wft_pkg::NUM_EP-1:0] engine_flag,
    input wire logic prog_end,
    input wire logic [wft_pkg::BUS_W-1:0] pdb_in,
    output logic [wft_pkg::BUS_W-1:0] pdb_out,
    output logic [wft_pkg::BUS_W-1:0] pdb_oe,
    input wire logic [wft_pkg::BUS_W-1:0] fifo_rdata,
    output logic fifo_pop,
    output logic fifo_push,
    output logic [wft_pkg::BUS_W-1:0] fifo_wdata,
    output logic [1:0] fifo_ep,
    output logic busy
);
    import wft_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [NUM_EP*2-1:0] flag_sel_r;
    logic [NUM_EP*2-1:0] flag_sel_nxt;
    logic [NUM_EP-1:0] stop_r;
    logic [NUM_EP-1:0] stop_nxt;
    logic wide_r;
    logic wide_nxt;
    logic [7:0] data_hi_r;
    logic [7:0] data_hi_nxt;
    logic [7:0] data_lo_r;
    logic [7:0] data_lo_nxt;
    logic [TC_W-1:0] tc_r;
    logic [TC_W-1:0] tc_nxt;
    wft_state_type state_r;
    wft_state_type state_nxt;
    wft_kind_type kind_r;
    wft_kind_type kind_nxt;
    logic [1:0] ep_r;
    logic [1:0] ep_nxt;
    logic [BUS_W-1:0] out_r;
    logic [BUS_W-1:0] out_nxt;
    logic [BUS_W-1:0] oe_r;
    logic [BUS_W-1:0] oe_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    logic [BUS_W-1:0] bus_sync;
    logic start_req;
    wft_kind_type start_kind;
    logic [1:0] start_ep;
    logic [BUS_W-1:0] drive_mask;
    logic flag_stop;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    wft_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(pdb_in),
        .sync_out(bus_sync)
    );

    wft_flag_mux u_flag_mux (
        .fifo_flags(fifo_flags),
        .flag_choice_field(flag_sel_r),
        .engine_flag(engine_flag)
    );

    // narrow mode drives only the low byte lanes
    assign drive_mask = wide_r ? 16'hffff : 16'h00ff;
    // selected flag ends a fifo transaction only when stop is enabled
    assign flag_stop = stop_r[ep_r] & engine_flag[ep_r];

    // ------------------------------------------------------------
    // register file and engine next state
    // ------------------------------------------------------------
    always_comb
    begin
        flag_sel_nxt = flag_sel_r;
        stop_nxt = stop_r;
        wide_nxt = wide_r;
        data_hi_nxt = data_hi_r;
        data_lo_nxt = data_lo_r;
        tc_nxt = tc_r;
        state_nxt = state_r;
        kind_nxt = kind_r;
        ep_nxt = ep_r;
        out_nxt = out_r;
        oe_nxt = oe_r;
        rdata_nxt = 8'h00;
        start_req = 1'b0;
        start_kind = K_SINGLE_WR;
        start_ep = 2'h0;
        fifo_pop = 1'b0;
        fifo_push = 1'b0;

        // software writes; busy engine keeps its count
        if (reg_wr)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (reg_addr == OFS_FLAG_SELECT[e])
                    flag_sel_nxt[e*2 +: 2] = reg_wdata[FLAG_CHOICE_LSB +: 2];
                else if (reg_addr == OFS_FLAG_STOP[e])
                    stop_nxt[e] = reg_wdata[STOP_BIT_POS];
                else if (reg_addr == OFS_FIFO_TRIGGER[e]
                        && reg_wdata == TRIGGER_WRITE_VALUE)
                begin
                    start_req = 1'b1;
                    start_kind = K_FIFO_WR;
                    start_ep = e[1:0];
                end
            end
            for (int b = 0; b < 4; b++)
            begin
                if (reg_addr == OFS_TC_BYTE[b] && state_r == ST_IDLE)
                    tc_nxt[(3-b)*8 +: 8] = reg_wdata;
            end
            if (reg_addr == OFS_SINGLE_HIGH)
                data_hi_nxt = reg_wdata;
            else if (reg_addr == OFS_SINGLE_LOW)
            begin
                data_lo_nxt = reg_wdata;
                start_req = 1'b1;
                start_kind = K_SINGLE_WR;
            end
            else if (reg_addr == OFS_SINGLE_LOW_QUIET)
                data_lo_nxt = reg_wdata;
            else if (reg_addr == OFS_BUS_CONFIG)
                wide_nxt = reg_wdata[WIDE_BIT_POS];
        end

        // software reads, answered in the next cycle
        if (reg_rd)
        begin
            for (int e = 0; e < NUM_EP; e++)
            begin
                if (reg_addr == OFS_FLAG_SELECT[e])
                    rdata_nxt = {6'h00, flag_sel_r[e*2 +: 2]};
                else if (reg_addr == OFS_FLAG_STOP[e])
                    rdata_nxt = {7'h00, stop_r[e]};
                else if (reg_addr == OFS_FIFO_TRIGGER[e])
                begin
                    start_req = 1'b1;
                    start_kind = K_FIFO_RD;
                    start_ep = e[1:0];
                end
            end
            for (int b = 0; b < 4; b++)
            begin
                if (reg_addr == OFS_TC_BYTE[b])
                    rdata_nxt = tc_r[(3-b)*8 +: 8];
            end
            if (reg_addr == OFS_SINGLE_HIGH)
                rdata_nxt = data_hi_r;
            else if (reg_addr == OFS_SINGLE_LOW)
            begin
                rdata_nxt = data_lo_r;
                start_req = 1'b1;
                start_kind = K_SINGLE_RD;
            end
            else if (reg_addr == OFS_SINGLE_LOW_QUIET)
                rdata_nxt = data_lo_r;
            else if (reg_addr == OFS_BUS_CONFIG)
                rdata_nxt = {7'h00, wide_r};
            else if (reg_addr == OFS_ENGINE_STATUS)
                rdata_nxt = {6'h00, state_r};
        end

        // waveform engine sequence
        case (state_r)
            ST_IDLE:
            begin
                oe_nxt = '0;
                if (start_req)
                begin
                    state_nxt = ST_RUN;
                    kind_nxt = start_kind;
                    ep_nxt = start_ep;
                end
            end
            ST_RUN:
            begin
                case (kind_r)
                    K_SINGLE_WR:
                    begin
                        out_nxt = {data_hi_r, data_lo_r} & drive_mask;
                        oe_nxt = drive_mask;
                        state_nxt = ST_DONE;
                    end
                    K_SINGLE_RD:
                    begin
                        data_lo_nxt = bus_sync[7:0];
                        if (wide_r)
                            data_hi_nxt = bus_sync[15:8];
                        state_nxt = ST_DONE;
                    end
                    default:
                    begin
                        if (flag_stop)
                            state_nxt = ST_DONE;
                        else
                        begin
                            if (kind_r == K_FIFO_WR)
                            begin
                                fifo_pop = 1'b1;
                                out_nxt = fifo_rdata & drive_mask;
                                oe_nxt = drive_mask;
                            end
                            else
                                fifo_push = 1'b1;
                            // live count, zero treated as one
                            if (tc_r <= TC_RESET)
                            begin
                                tc_nxt = '0;
                                state_nxt = ST_DONE;
                            end
                            else
                            begin
                                tc_nxt = tc_r - TC_RESET;
                                if (prog_end)
                                    state_nxt = ST_DONE;
                            end
                        end
                    end
                endcase
            end
            ST_DONE:
            begin
                oe_nxt = '0;
                state_nxt = ST_IDLE;
            end
            default:
            begin
                oe_nxt = '0;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            flag_sel_r <= {NUM_EP{FLAG_CHOICE_RESET}};
            stop_r <= {NUM_EP{STOP_RESET}};
            wide_r <= WIDE_RESET;
            data_hi_r <= DATA_RESET;
            data_lo_r <= DATA_RESET;
            tc_r <= TC_RESET;
            state_r <= ST_IDLE;
            kind_r <= K_SINGLE_WR;
            ep_r <= 2'h0;
            out_r <= '0;
            oe_r <= '0;
            rdata_r <= 8'h00;
        end
        else if (ce)
        begin
            flag_sel_r <= flag_sel_nxt;
            stop_r <= stop_nxt;
            wide_r <= wide_nxt;
            data_hi_r <= data_hi_nxt;
            data_lo_r <= data_lo_nxt;
            tc_r <= tc_nxt;
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            ep_r <= ep_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_r;
    assign pdb_out = out_r;
    assign pdb_oe = oe_r;
    assign fifo_wdata = bus_sync; // captured bus word
    assign fifo_ep = ep_r;
    assign busy = (state_r != ST_IDLE);

endmodule : wft_ctrl

// ### test/wft_ctrl_asserts.sv
`timescale 1ns/1ps
module wft_ctrl_asserts
    import wft_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wft_pkg::wft_flags_type [3:0] fifo_flags,
    input wire logic [3:0] engine_flag,
    input wire logic [15:0] pdb_oe,
    input wire logic fifo_pop,
    input wire logic fifo_push,
    input wire logic [1:0] fifo_ep,
    input wire logic busy
);
    logic [3:0] any_f;
    logic go;

    // any flag of each endpoint, and an accepted strobe
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            any_f[i] = |fifo_flags[i];
        go = ce && !busy;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ----
    // checks
    // ----
    AST_RST_SEL: assert property (
        $rose(rst_n) |-> engine_flag == {fifo_flags[3].prog,
        fifo_flags[2].prog, fifo_flags[1].prog, fifo_flags[0].prog})
        else $error("select not programmable after reset");
    AST_ONE_FLAG: assert property (
        (engine_flag & ~any_f) == 4'h0)
        else $error("engine flag without a source flag");
    AST_TRIG_WR: assert property (
        go && reg_wr && reg_addr == OFS_FIFO_TRIGGER[2]
        && reg_wdata == TRIGGER_WRITE_VALUE |=> busy && fifo_ep == 2'h2)
        else $error("trigger write did not start");
    AST_TRIG_IGN: assert property (
        go && reg_wr && reg_addr == OFS_FIFO_TRIGGER[0]
        && reg_wdata != TRIGGER_WRITE_VALUE |=> !busy)
        else $error("trigger started on other value");
    AST_TRIG_RD: assert property (
        go && reg_rd && reg_addr == OFS_FIFO_TRIGGER[3]
        |=> busy && fifo_ep == 2'h3 && reg_rdata == 8'h00)
        else $error("trigger read did not start");
    AST_SGL: assert property (
        go && (reg_wr || reg_rd) && reg_addr == OFS_SINGLE_LOW
        |=> busy [*2] ##1 !busy)
        else $error("single transfer timing wrong");
    AST_QUIET: assert property (
        go && (reg_wr || reg_rd) && reg_addr == OFS_SINGLE_LOW_QUIET
        |=> !busy)
        else $error("quiet access started engine");
    AST_POP: assert property (
        fifo_pop || fifo_push |-> busy && !(fifo_pop && fifo_push))
        else $error("fifo strobe outside transfer");
    AST_OE: assert property (
        pdb_oe != 16'h0000 |-> busy
        && (pdb_oe == 16'h00ff || pdb_oe == 16'hffff))
        else $error("bus enable wrong");
endmodule : wft_ctrl_asserts

bind wft_ctrl wft_ctrl_asserts chk_u (.mclk, .rst_n, .ce, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fifo_flags, .engine_flag,
    .pdb_oe, .fifo_pop, .fifo_push, .fifo_ep, .busy);

// ### test/wft_periph_model.sv
`timescale 1ns/1ps
module wft_periph_model (
    input wire logic mclk,
    input wire logic [15:0] pdb_out,
    input wire logic [15:0] pdb_oe,
    input wire logic fifo_pop,
    input wire logic fifo_push,
    input wire logic drive_en,
    input wire logic [15:0] drive_val,
    output logic [15:0] pdb_in,
    output logic [15:0] fifo_rdata,
    output int pops,
    output int pushes
);
    logic [15:0] junk_r = 16'h0f0f;

    // device wins where enabled; released lines show drive_val while drive_en is high, else toggle each cycle
    assign pdb_in = (pdb_oe & pdb_out)
        | (~pdb_oe & (drive_en ? drive_val : junk_r));

    initial
    begin
        fifo_rdata = 16'h1000;
        pops = 0;
        pushes = 0;
    end

    // show-ahead source word and transfer counts
    always @(posedge mclk)
    begin
        junk_r <= ~junk_r;
        fifo_rdata <= fifo_rdata + {15'h0, fifo_pop};
        pops <= pops + int'(fifo_pop);
        pushes <= pushes + int'(fifo_push);
    end
endmodule : wft_periph_model

// ### test/wft_ctrl_bench.sv
`timescale 1ns/1ps
module wft_ctrl_bench;
    import wft_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic prog_end = 1'b0;
    logic drive_en = 1'b1;
    logic [15:0] drive_val = 16'h5aa5;
    wft_flags_type [3:0] fifo_flags = '0;
    logic [7:0] reg_rdata, d, pk;
    logic [3:0] engine_flag;
    logic [15:0] pdb_in, pdb_out, pdb_oe, fifo_rdata, fifo_wdata;
    logic fifo_pop, fifo_push, busy;
    logic [1:0] fifo_ep, e;
    int pops, pushes, n;
    int err_count = 0;
    int n_tests = 0;
    // address, write value, expected read back
    localparam logic [31:0] ROWS [10] = '{32'he6d20101, 32'he6da0202,
        32'he6e20303, 32'he6ea0101, 32'he6d30101, 32'he6db0101,
        32'he6e30101, 32'he6eb0101, 32'he6f25a5a, 32'h12345500};

    always #5 mclk = ~mclk;

    wft_ctrl dut_u (.mclk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .fifo_flags, .engine_flag, .prog_end,
        .pdb_in, .pdb_out, .pdb_oe, .fifo_rdata, .fifo_pop, .fifo_push,
        .fifo_wdata, .fifo_ep, .busy);
    wft_periph_model far_u (.mclk, .pdb_out, .pdb_oe, .fifo_pop,
        .fifo_push, .drive_en, .drive_val, .pdb_in, .fifo_rdata, .pops,
        .pushes);

    // ----
    // helpers
    // ----
    task automatic chk(input logic [15:0] got, exp, input string nm);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic wait_idle();
        for (int k = 0; k < 300 && busy === 1'b1; k++)
            tick();
        chk(busy, 1'b0, "busy_end");
    endtask : wait_idle

    // load count, start by write or read, count words moved
    task automatic xfer(input logic [15:0] a, input logic rdk, peek,
        input logic [7:0] t);
        int c0;
        for (int i = 0; i < 4; i++)
            wr(OFS_TC_BYTE[i], (i == 3) ? t : 8'h00);
        c0 = pops + pushes;
        if (rdk)
            rd(a, d);
        else
            wr(a, TRIGGER_WRITE_VALUE);
        #1;
        e = fifo_ep;
        if (peek)
            rd(OFS_TC_BYTE[3], pk);
        wait_idle();
        n = pops + pushes - c0;
    endtask : xfer

    initial
    begin
        #200000;
        err_count++;
        conclude();
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_FLAG_SELECT[3], d);
        chk(d, 8'h00, "sel_rst");
        rd(OFS_FLAG_STOP[2], d);
        chk(d, 8'h00, "stop_rst");
        rd(OFS_TC_BYTE[3], d);
        chk(d, 8'h01, "tc_rst");
        foreach (ROWS[i])
        begin
            wr(ROWS[i][31:16], ROWS[i][15:8]);
            rd(ROWS[i][31:16], d);
            chk(d, ROWS[i][7:0], "row");
        end
        for (int ep = 0; ep < 4; ep++)
            for (int c = 0; c < 4; c++)
            begin
                wr(OFS_FLAG_SELECT[ep], 8'(c));
                for (int p = 0; p < 3; p++)
                begin
                    @(posedge mclk);
                    fifo_flags <= {4{3'b100 >> p}};
                    #1;
                    chk(engine_flag[ep], c == p, "mux");
                end
            end
        xfer(OFS_FIFO_TRIGGER[2], 1'b0, 1'b0, 8'h02);
        chk(n, 2, "fifo_wr_words");
        chk(e, 2'h2, "fifo_wr_ep");
        xfer(OFS_FIFO_TRIGGER[3], 1'b1, 1'b0, 8'h03);
        chk(n, 3, "fifo_rd_words");
        chk(e, 2'h3, "fifo_rd_ep");
        chk(d, 8'h00, "trig_rdata");
        xfer(OFS_FIFO_TRIGGER[0], 1'b0, 1'b1, 8'h06);
        chk(pk inside {[8'h01:8'h05]}, 1'b1, "tc_live");
        chk(n, 6, "tc_words");
        wr(OFS_FLAG_SELECT[2], 8'h01);
        fifo_flags <= {4{3'b010}};
        wr(OFS_FLAG_STOP[2], 8'h00);
        xfer(OFS_FIFO_TRIGGER[2], 1'b0, 1'b0, 8'h04);
        chk(n, 4, "no_stop");
        wr(OFS_FLAG_STOP[2], 8'h01);
        xfer(OFS_FIFO_TRIGGER[2], 1'b0, 1'b0, 8'h04);
        chk(n, 0, "stop");
        @(posedge mclk);
        prog_end <= 1'b1;
        xfer(OFS_FIFO_TRIGGER[1], 1'b0, 1'b0, 8'h14);
        chk(n, 1, "prog_end");
        @(posedge mclk);
        prog_end <= 1'b0;
        wr(OFS_FIFO_TRIGGER[0], 8'h7f);
        #1;
        chk(busy, 1'b0, "trig_ign");
        wr(OFS_BUS_CONFIG, 8'h01);
        wr(OFS_SINGLE_HIGH, 8'ha5);
        wr(OFS_SINGLE_LOW, 8'h3c);
        for (int k = 0; k < 20 && pdb_oe !== 16'hffff; k++)
            tick();
        chk(pdb_out, 16'ha53c, "sgl_wr");
        wait_idle();
        chk(pdb_oe, 16'h0000, "oe_off");
        repeat (2) @(posedge mclk);
        rd(OFS_SINGLE_LOW, d);
        chk(d, 8'h3c, "sgl_old");
        wait_idle();
        rd(OFS_SINGLE_HIGH, d);
        chk(d, 8'h5a, "sgl_hi");
        rd(OFS_SINGLE_LOW_QUIET, d);
        chk(d, 8'ha5, "quiet_rd");
        chk(busy, 1'b0, "quiet_idle");
        xfer(OFS_FIFO_TRIGGER[3], 1'b1, 1'b0, 8'h01);
        chk(fifo_wdata, 16'h5aa5, "fifo_word");
        // reset in the middle of a long fifo transfer
        wr(OFS_TC_BYTE[3], 8'h40);
        wr(OFS_FIFO_TRIGGER[1], TRIGGER_WRITE_VALUE);
        rd(OFS_ENGINE_STATUS, d);
        chk(d, 8'h01, "status_run");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(busy, 1'b0, "rst_busy");
        chk(pdb_oe, 16'h0000, "rst_oe");
        rd(OFS_TC_BYTE[3], d);
        chk(d, 8'h01, "rst_tc");
        rd(OFS_FLAG_STOP[2], d);
        chk(d, 8'h00, "rst_stop");
        rd(OFS_FLAG_SELECT[1], d);
        chk(d, 8'h00, "rst_sel");
        conclude();
    end
endmodule : wft_ctrl_bench
